/* core/ld_defs.svh */
`ifndef LD_DEFS_SVH
`define LD_DEFS_SVH

// word layout
`define LD_WORD_W      16
`define LD_CODE_W      12
`define LD_SELH_BIT    15
`define LD_FAST_BIT    14
`define LD_PD_BIT      13
`define LD_SELL_BIT    12
`define LD_CODE_MSB    11
`define LD_LAST_BIT    5'h0f
`define LD_BYTE_LAST   4'h7
`define LD_WORD_LAST   4'hf

// synchroniser lanes and idle pin levels
`define LD_PIN_CS      2
`define LD_PIN_SCLK    1
`define LD_PIN_DIN     0
`define LD_PIN_IDLE    3'h6

// reset values
`define LD_CODE_RST    12'h000
`define LD_WORD_RST    16'h0000

// timing: clock period and pin times in ns, then pin times in clock cycles
`define LD_CLK_NS      5
`define LD_HALF_NS     25
`define LD_CSH_NS      50
`define LD_HALF_CYC    ((`LD_HALF_NS + `LD_CLK_NS - 1) / `LD_CLK_NS)
`define LD_CSH_CYC     ((`LD_CSH_NS + `LD_CLK_NS - 1) / `LD_CLK_NS)
`define LD_GAP_CYC     16

// controller register offsets (byte addresses)
`define LD_REG_WORD    8'h00
`define LD_REG_STAT    8'h04
`define LD_REG_CFG     8'h08
`define LD_STAT_BUSY   0
`define LD_CFG_BYTE    0

`endif

/* core/ld_pkg.sv */
`default_nettype none

package ld_pkg;

  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_SHIFT = 2'b01,
    D_ARMED = 2'b11,
    D_DONE  = 2'b10
  } ld_dev_state_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_HIGH = 3'b001,
    C_LOW  = 3'b011,
    C_TAIL = 3'b010,
    C_HOLD = 3'b110
  } ld_ctl_state_e;

  typedef enum logic [1:0] {
    T_B_BUF  = 2'b00,
    T_BUF    = 2'b01,
    T_A_XFER = 2'b10,
    T_RSVD   = 2'b11
  } ld_target_e;

endpackage

`default_nettype wire

/* core/ld_link_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface ld_link_if;
  logic cs_n;
  logic sclk;
  logic din;

  modport ctl (
    output cs_n,
    output sclk,
    output din
  );

  modport dev (
    input cs_n,
    input sclk,
    input din
  );
endinterface

`default_nettype wire

/* core/ld_dev.sv */
// Summary of operation
// RULE1: select fall starts; clock falls shift MSB first
// RULE2: after sixteen bits or select rise, load latches
// RULE3: reset clears channels, buffer and control state
// RULE4: bits 15..12 program bits, 11..0 code
// RULE5: select code picks channel B, buffer, A
// RULE6: selected target takes the twelve code bits
// RULE7: speed bit one fast, zero slow
// RULE8: power bit one powers down, ignores rest
// RULE9: update on first clock rise after sixteenth fall
// RULE10: buffer word then A word updates both
// RULE11: controller lowers select first; bytes pair up
// RULE12: controller keeps shift clock at most 20 MHz
// RULE13: reserved select code leaves data latches alone
// RULE14: early select rise transfers once, then waits
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ld_defs.svh"

module ld_dev (
  // system
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // serial link
  ld_link_if.dev                      link,
  // converter codes
  output logic [`LD_CODE_W-1:0]       dac_a_o,
  output logic [`LD_CODE_W-1:0]       dac_b_o,
  output logic [`LD_CODE_W-1:0]       buf_o,
  // control state
  output logic                        fast_mode_o,
  output logic                        power_down_o,
  // update strobes
  output logic                        upd_a_o,
  output logic                        upd_b_o,
  output logic                        rsvd_o
);

  localparam logic [2:0] PIN_IDLE = `LD_PIN_IDLE;

  // pin synchronisers
  logic [2:0]                  pin_w;
  logic [2:0]                  s1_q;
  logic [2:0]                  s2_q;
  logic [2:0]                  s3_q;

  // frame state
  ld_pkg::ld_dev_state_e       st_q;
  ld_pkg::ld_dev_state_e       st_d;
  logic [`LD_WORD_W-1:0]       sh_q;
  logic [4:0]                  cnt_q;

  // decoded events
  logic                        cs_fall_w;
  logic                        cs_rise_w;
  logic                        sclk_fall_w;
  logic                        sclk_rise_w;
  logic                        din_w;
  logic                        take_w;
  logic [`LD_WORD_W-1:0]       word_nx_w;

  // commit path
  logic                        commit_w;
  logic [`LD_WORD_W-1:0]       cword_w;
  logic                        pd_w;
  logic                        fast_w;
  ld_pkg::ld_target_e          sel_w;
  logic [`LD_CODE_W-1:0]       code_w;
  logic                        live_w;
  logic                        wr_a_w;
  logic                        wr_b_w;
  logic                        wr_buf_w;
  logic                        wr_rsvd_w;

  // output registers
  logic [`LD_CODE_W-1:0]       dac_a_q;
  logic [`LD_CODE_W-1:0]       dac_b_q;
  logic [`LD_CODE_W-1:0]       buf_q;
  logic                        fast_q;
  logic                        pd_q;
  logic                        upd_a_q;
  logic                        upd_b_q;
  logic                        rsvd_q;

  assign pin_w = {link.cs_n, link.sclk, link.din};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
    end else if (ce_i) begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges seen on the second and third stages only
  assign cs_fall_w   = s3_q[`LD_PIN_CS] & ~s2_q[`LD_PIN_CS];
  assign cs_rise_w   = ~s3_q[`LD_PIN_CS] & s2_q[`LD_PIN_CS];
  assign sclk_fall_w = s3_q[`LD_PIN_SCLK] & ~s2_q[`LD_PIN_SCLK];
  assign sclk_rise_w = ~s3_q[`LD_PIN_SCLK] & s2_q[`LD_PIN_SCLK];
  assign din_w       = s2_q[`LD_PIN_DIN];

  // msb first into the shift register
  assign word_nx_w = {sh_q[`LD_WORD_W-2:0], din_w}; // RULE1
  assign take_w    = (st_q == ld_pkg::D_SHIFT) & sclk_fall_w
                     & ~cs_rise_w;

  always_comb begin
    st_d     = st_q;
    commit_w = 1'b0;
    cword_w  = sh_q;
    case (st_q)
      ld_pkg::D_IDLE: begin
        if (cs_fall_w) begin
          st_d = ld_pkg::D_SHIFT; // RULE1
        end
      end
      ld_pkg::D_SHIFT: begin
        if (cs_rise_w) begin
          // partial word still moves once
          st_d     = ld_pkg::D_IDLE; // RULE14
          commit_w = (cnt_q != 5'h00) | sclk_fall_w; // RULE2
          cword_w  = sclk_fall_w ? word_nx_w : sh_q;
        end else if (sclk_fall_w && cnt_q == `LD_LAST_BIT) begin
          st_d = ld_pkg::D_ARMED;
        end
      end
      ld_pkg::D_ARMED: begin
        // first rise after the sixteenth fall, or select rising
        if (sclk_rise_w | cs_rise_w) begin
          commit_w = 1'b1; // RULE9
          st_d     = cs_rise_w ? ld_pkg::D_IDLE : ld_pkg::D_DONE;
        end
      end
      ld_pkg::D_DONE: begin
        // further clocks ignored until select rises
        if (cs_rise_w) begin
          st_d = ld_pkg::D_IDLE; // RULE14
        end
      end
      default: begin
        st_d = ld_pkg::D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ld_pkg::D_IDLE;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q  <= `LD_WORD_RST;
      cnt_q <= 5'h00;
    end else if (ce_i) begin
      if (cs_fall_w) begin
        sh_q  <= `LD_WORD_RST;
        cnt_q <= 5'h00;
      end else if (take_w) begin
        sh_q  <= word_nx_w; // RULE1
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // field split of the committed word
  assign sel_w  = ld_pkg::ld_target_e'({cword_w[`LD_SELH_BIT],
                                        cword_w[`LD_SELL_BIT]}); // RULE4
  assign fast_w = cword_w[`LD_FAST_BIT];
  assign pd_w   = cword_w[`LD_PD_BIT];
  assign code_w = cword_w[`LD_CODE_MSB:0]; // RULE4

  // power-down word touches nothing else
  assign live_w    = commit_w & ~pd_w; // RULE8
  assign wr_a_w    = live_w & (sel_w == ld_pkg::T_A_XFER); // RULE5
  assign wr_b_w    = live_w & (sel_w == ld_pkg::T_B_BUF); // RULE5
  assign wr_buf_w  = live_w & ((sel_w == ld_pkg::T_B_BUF)
                     | (sel_w == ld_pkg::T_BUF)); // RULE5
  assign wr_rsvd_w = live_w & (sel_w == ld_pkg::T_RSVD); // RULE13

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_a_q <= `LD_CODE_RST; // RULE3
      dac_b_q <= `LD_CODE_RST; // RULE3
      buf_q   <= `LD_CODE_RST; // RULE3
    end else if (ce_i) begin
      if (wr_a_w) begin
        dac_a_q <= code_w; // RULE6
      end
      // channel B copies the old buffer on an A word
      if (wr_a_w) begin
        dac_b_q <= buf_q; // RULE10
      end else if (wr_b_w) begin
        dac_b_q <= code_w; // RULE6
      end
      if (wr_buf_w) begin
        buf_q <= code_w; // RULE6
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_q <= 1'b0; // RULE3
      pd_q   <= 1'b0; // RULE3
    end else if (ce_i && commit_w) begin
      pd_q <= pd_w; // RULE8
      if (!pd_w) begin
        fast_q <= fast_w; // RULE7
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_a_q <= 1'b0;
      upd_b_q <= 1'b0;
      rsvd_q  <= 1'b0;
    end else if (ce_i) begin
      upd_a_q <= wr_a_w; // RULE10
      upd_b_q <= wr_a_w | wr_b_w; // RULE10
      rsvd_q  <= wr_rsvd_w;
    end
  end

  assign dac_a_o      = dac_a_q;
  assign dac_b_o      = dac_b_q;
  assign buf_o        = buf_q;
  assign fast_mode_o  = fast_q;
  assign power_down_o = pd_q;
  assign upd_a_o      = upd_a_q;
  assign upd_b_o      = upd_b_q;
  assign rsvd_o       = rsvd_q;

endmodule

`default_nettype wire

/* core/ld_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ld_defs.svh"

module ld_ctl #(
  parameter int HALF_CYC = `LD_HALF_CYC,
  parameter int CSH_CYC  = `LD_CSH_CYC,
  parameter int GAP_CYC  = `LD_GAP_CYC
) (
  // system
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // serial link
  ld_link_if.ctl             link
);

  localparam logic [7:0] HALF_LD = 8'(HALF_CYC - 1);
  localparam logic [7:0] CSH_LD  = 8'(CSH_CYC - 1);
  localparam logic [7:0] GAP_LD  = 8'(GAP_CYC - 1);

  ld_pkg::ld_ctl_state_e     st_q;
  logic [7:0]                tmr_q;
  logic [3:0]                bit_q;
  logic [`LD_WORD_W-1:0]     sh_q;
  logic [`LD_WORD_W-1:0]     word_q;
  logic                      byte_q;
  logic                      cs_q;
  logic                      sclk_q;
  logic                      din_q;
  logic                      ack_q;
  logic [31:0]               rd_q;

  logic                      req_w;
  logic                      wr_w;
  logic                      busy_w;
  logic                      go_w;
  logic                      tmo_w;
  logic [31:0]               rd_w;

  assign req_w  = wb_cyc_i & wb_stb_i;
  assign wr_w   = req_w & wb_we_i & ack_q;
  assign busy_w = (st_q != ld_pkg::C_IDLE);
  assign tmo_w  = (tmr_q == 8'h00);
  // a word written while busy is dropped
  assign go_w   = wr_w & (wb_adr_i == `LD_REG_WORD)
                  & (wb_sel_i[1:0] == 2'h3) & ~busy_w;

  assign rd_w = (wb_adr_i == `LD_REG_WORD) ? {16'h0000, word_q}
              : (wb_adr_i == `LD_REG_STAT) ? {31'h0, busy_w}
              : (wb_adr_i == `LD_REG_CFG)  ? {31'h0, byte_q}
              : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rd_q   <= 32'h0000_0000;
      byte_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req_w & ~ack_q;
      rd_q  <= rd_w;
      if (wr_w && wb_adr_i == `LD_REG_CFG && wb_sel_i[0]) begin
        byte_q <= wb_dat_i[`LD_CFG_BYTE];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ld_pkg::C_IDLE;
      tmr_q  <= 8'h00;
      bit_q  <= 4'h0;
      sh_q   <= `LD_WORD_RST;
      word_q <= `LD_WORD_RST;
      cs_q   <= 1'b1;
      sclk_q <= 1'b1;
      din_q  <= 1'b0;
    end else if (ce_i) begin
      if (!tmo_w) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (st_q)
        ld_pkg::C_IDLE: begin
          if (go_w) begin
            // select low a half period before first fall
            word_q <= wb_dat_i[`LD_WORD_W-1:0];
            sh_q   <= wb_dat_i[`LD_WORD_W-1:0];
            din_q  <= wb_dat_i[`LD_WORD_W-1]; // RULE11
            cs_q   <= 1'b0; // RULE11
            bit_q  <= 4'h0;
            tmr_q  <= HALF_LD;
            st_q   <= ld_pkg::C_HIGH;
          end
        end
        ld_pkg::C_HIGH: begin
          if (tmo_w) begin
            sclk_q <= 1'b0; // RULE1
            tmr_q  <= HALF_LD; // RULE12
            st_q   <= ld_pkg::C_LOW;
          end
        end
        ld_pkg::C_LOW: begin
          if (tmo_w) begin
            sclk_q <= 1'b1; // RULE12
            sh_q   <= {sh_q[`LD_WORD_W-2:0], 1'b0};
            din_q  <= sh_q[`LD_WORD_W-2];
            bit_q  <= bit_q + 4'h1;
            if (bit_q == `LD_WORD_LAST) begin
              tmr_q <= HALF_LD;
              st_q  <= ld_pkg::C_TAIL;
            end else begin
              // two byte writes share one select window
              tmr_q <= (byte_q && bit_q == `LD_BYTE_LAST)
                       ? GAP_LD : HALF_LD; // RULE11
              st_q  <= ld_pkg::C_HIGH;
            end
          end
        end
        ld_pkg::C_TAIL: begin
          if (tmo_w) begin
            cs_q  <= 1'b1;
            tmr_q <= CSH_LD;
            st_q  <= ld_pkg::C_HOLD;
          end
        end
        ld_pkg::C_HOLD: begin
          if (tmo_w) begin
            st_q <= ld_pkg::C_IDLE;
          end
        end
        default: begin
          st_q <= ld_pkg::C_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rd_q;
  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.din  = din_q;

endmodule

`default_nettype wire

/* test/ld_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module ld_chk (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // link pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  // device outputs
  input  wire logic [11:0] dac_a_o,
  input  wire logic [11:0] dac_b_o,
  input  wire logic [11:0] buf_o,
  input  wire logic        power_down_o,
  input  wire logic        upd_a_o,
  input  wire logic        upd_b_o,
  input  wire logic        rsvd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [4:0] nfall_q;
  logic       sclk_q;

  // falls seen on the pin inside the current frame
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    if (rst_i || cs_n) nfall_q <= 5'h00;
    else if (sclk_q && !sclk) nfall_q <= nfall_q + 5'h01;
  end

  a_idle_sclk: assert property (cs_n |-> sclk)
    else $error("shift clock not high outside frame");
  a_din_hold: assert property (!sclk && !cs_n |-> $stable(din))
    else $error("data moved while shift clock low");
  a_cs_lead: assert property ($fell(cs_n) |-> sclk [*4])
    else $error("shift clock fell too soon after select");
  a_low_width: assert property ($fell(sclk) |-> !sclk [*5])
    else $error("shift clock low phase short");
  a_high_width: assert property ($rose(sclk) && !cs_n |-> sclk [*5])
    else $error("shift clock high phase short");
  a_sixteen_falls: assert property ($rose(cs_n) |-> nfall_q == 5'h10)
    else $error("frame closed without sixteen falls");
  a_update_edge: assert property ((upd_a_o || upd_b_o) |->
    nfall_q == 5'h10 && sclk && !cs_n)
    else $error("output update at wrong moment");
  a_both_update: assert property (upd_a_o |-> upd_b_o)
    else $error("channel A updated without channel B");
  a_a_hold: assert property (!upd_a_o |-> $stable(dac_a_o))
    else $error("channel A moved without update");
  a_b_hold: assert property (!upd_b_o |-> $stable(dac_b_o))
    else $error("channel B moved without update");
  a_one_pulse: assert property (upd_b_o |=> !upd_b_o)
    else $error("update pulse longer than one cycle");
  a_pd_only: assert property ($rose(power_down_o) |->
    $stable(buf_o) && !upd_b_o)
    else $error("power-down word changed data");
  a_rsvd_keep: assert property (rsvd_o |->
    $stable(buf_o) && !upd_b_o)
    else $error("reserved word changed data");
endmodule

`default_nettype wire

/* test/dual_dac_serial_word_loader_test.sv */
`timescale 1ns/100ps
`default_nettype none

module dual_dac_serial_word_loader_test;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [11:0] a, b, bf, a2, b2, bf2, ea, eb, ebf;
  logic        fm, pd, fm2, pd2, ua, ub, rs, ub2, ef, ep, ce2;
  logic [15:0] w;
  logic [37:0] exp_q[$];
  int          errors, checks, cycles, nub2, i, nua, nrs, eua, ers;

  ld_link_if ld_link_if_i ();
  ld_link_if ld_link_if_i2 ();
  ld_ctl ld_ctl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .link(ld_link_if_i.ctl));
  ld_dev ld_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .link(ld_link_if_i.dev), .dac_a_o(a), .dac_b_o(b), .buf_o(bf),
    .fast_mode_o(fm), .power_down_o(pd), .upd_a_o(ua), .upd_b_o(ub),
    .rsvd_o(rs));
  ld_dev ld_dev_i2 (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce2),
    .link(ld_link_if_i2.dev), .dac_a_o(a2), .dac_b_o(b2), .buf_o(bf2),
    .fast_mode_o(fm2), .power_down_o(pd2), .upd_a_o(), .upd_b_o(ub2),
    .rsvd_o());
  ld_chk ld_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n(ld_link_if_i.cs_n), .sclk(ld_link_if_i.sclk),
    .din(ld_link_if_i.din), .dac_a_o(a), .dac_b_o(b), .buf_o(bf),
    .power_down_o(pd), .upd_a_o(ua), .upd_b_o(ub), .rsvd_o(rs));

  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (ub2 === 1'h1) nub2++;
    if (ua === 1'h1) nua++;
    if (rs === 1'h1) nrs++;
    if (cycles == 30000) begin
      errors++;
      give_verdict;
    end
  end

  task automatic wb(input logic wr, input logic [7:0] ad,
                    input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= ad;
    sel <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  function automatic void model(input logic [15:0] v);
    if (v[13]) begin
      ep = 1'h1;
    end else begin
      ef = v[14];
      ep = 1'h0;
      case ({v[15], v[12]})
        2'h0: begin
          eb = v[11:0];
          ebf = v[11:0];
        end
        2'h1: begin
          ebf = v[11:0];
        end
        2'h2: begin
          eb = ebf;
          ea = v[11:0];
          eua++;
        end
        default: begin
          ers++;
        end
      endcase
    end
    exp_q.push_back({ea, eb, ebf, ef, ep});
  endfunction

  // dup: second write while busy must be dropped
  task automatic send(input logic [15:0] v, input logic dup);
    wb(1'h1, 8'h00, 4'hf, {16'h0000, v});
    model(v);
    if (dup) wb(1'h1, 8'h00, 4'hf, {16'h0000, ~v});
    wb(1'h0, 8'h04, 4'hf, 32'h0);
    check({37'h0, rdat[0]}, 38'h1);
    do wb(1'h0, 8'h04, 4'hf, 32'h0); while (rdat[0] !== 1'h0);
    wb(1'h0, 8'h00, 4'hf, 32'h0);
    check({22'h0, rdat[15:0]}, {22'h0, v});
  endtask

  // frame cut short after twelve bits
  task automatic short_frame(input logic [11:0] v);
    int k;
    @(posedge clk_i);
    ld_link_if_i2.cs_n <= 1'h0;
    for (k = 11; k >= 0; k--) begin
      ld_link_if_i2.din <= v[k];
      repeat (5) @(posedge clk_i);
      ld_link_if_i2.sclk <= 1'h0;
      repeat (5) @(posedge clk_i);
      ld_link_if_i2.sclk <= 1'h1;
    end
    repeat (5) @(posedge clk_i);
    ld_link_if_i2.cs_n <= 1'h1;
    ld_link_if_i2.din <= ~v[0];
    // clock enable low must hold off the commit
    ce2 <= 1'h0;
    repeat (8) @(posedge clk_i);
    check({a2, b2, bf2, fm2, pd2}, 38'h0);
    ce2 <= 1'h1;
    repeat (8) @(posedge clk_i);
    check({a2, b2, bf2, fm2, pd2}, {12'h0, v, v, 2'h0});
    check(38'(nub2), 38'h1);
  endtask

  initial begin
    @(negedge rst_i);
    forever begin
      @(posedge ld_link_if_i.cs_n);
      repeat (5) @(posedge clk_i);
      if (exp_q.size() == 0) check(38'h0, 38'h1);
      else check({a, b, bf, fm, pd}, exp_q.pop_front());
    end
  end

  initial begin
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    rst_i = 1'h1;
    ce2 = 1'h1;
    errors = 0;
    checks = 0;
    cycles = 0;
    nub2 = 0;
    nua = 0;
    nrs = 0;
    eua = 0;
    ers = 0;
    ld_link_if_i2.cs_n = 1'h1;
    ld_link_if_i2.sclk = 1'h1;
    ld_link_if_i2.din = 1'h0;
    ea = 12'h000;
    eb = 12'h000;
    ebf = 12'h000;
    ef = 1'h0;
    ep = 1'h0;
    void'($urandom(68));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    check({a, b, bf, fm, pd}, 38'h0);
    check({a2, b2, bf2, fm2, pd2}, 38'h0);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      w = 16'($urandom);
      {w[14], w[15], w[12]} = 3'(i);
      w[13] = (i == 9);
      send(w, i == 4);
    end
    $display("test codes done");
    wb(1'h1, 8'h08, 4'h1, 32'h1);
    wb(1'h0, 8'h08, 4'hf, 32'h0);
    check({37'h0, rdat[0]}, 38'h1);
    send(16'($urandom) & 16'hdfff, 1'h0);
    wb(1'h1, 8'h08, 4'h1, 32'h0);
    $display("test byte mode done");
    wb(1'h0, 8'h40, 4'hf, 32'h0);
    check({6'h00, rdat}, 38'h0);
    // word write without both low lanes starts no frame
    wb(1'h1, 8'h00, 4'hc, 32'h0000_ffff);
    wb(1'h0, 8'h04, 4'hf, 32'h0);
    check({37'h0, rdat[0]}, 38'h0);
    short_frame(12'($urandom));
    $display("test short frame done");
    check(38'(nua), 38'(eua));
    check(38'(nrs), 38'(ers));
    check(38'(exp_q.size()), 38'h0);
    give_verdict;
  end
endmodule

`default_nettype wire
